// ### hdl/ssc_top.sv
// Low-power state controller: stop-grant, sleep, deep sleep, SMI entry,
// output tristate at init release and thermal trip, with an Avalon-MM slave.
// Assumes all plain inputs are synchronous to core_clk_in.
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module ssc_top (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Sideband pins
    input wire ssc_pkg::ssc_side_type side_n_in,
    input wire logic chip_init_n_in,
    input wire logic bus_clock_present_in,
    input wire logic [ssc_pkg::SSC_TEMP_W-1:0] junction_temp_in,
    // Unit requests
    input wire logic snoop_req_in,
    input wire logic int_req_in,
    input wire logic smm_exit_in,
    // Acknowledge transaction
    output logic ack_valid_out,
    input wire logic ack_ready_in,
    output logic ack_type_out,
    // Unit control
    output ssc_pkg::ssc_clk_type clk_en_out,
    output logic exec_en_out,
    output logic snoop_accept_out,
    output logic int_accept_out,
    output logic smm_active_out,
    output logic bus_out_en_out,
    // Open-drain status pins
    output logic thermal_trip_n_out,
    output logic thermal_trip_n_oe_out,
    output logic pending_break_n_out,
    output logic pending_break_n_oe_out,
    // Avalon-MM slave
    input wire logic [ssc_pkg::SSC_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [ssc_pkg::SSC_DATA_W-1:0] avs_writedata_in,
    output logic [ssc_pkg::SSC_DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out
);
    import ssc_pkg::*;

    // =====================================================================
    // Synchronised sideband levels
    ssc_side_type side_s;
    logic stp_act;
    logic slp_act;
    logic dps_act;

    // The stop clock line only reaches the state machine through this bank.
    ssc_sync_bank #(
        .WIDTH(SSC_SIDE_W),
        .IDLE(SSC_SIDE_IDLE)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(side_n_in),
        .sync_out(side_s)
    );

    assign stp_act = ~side_s.stop_clock_request_n;
    assign slp_act = ~side_s.sleep_request_n;
    assign dps_act = ~side_s.deep_sleep_request_n;

    // =====================================================================
    // Power state machine
    ssc_state_type state;
    ssc_state_type next_state;
    ssc_state_type saved_state;
    ssc_state_type next_saved_state;
    ssc_clk_type next_clk_en;
    logic init_q;
    logic init_prev;
    logic smi_prev_n;
    logic system_mgmt_mode;
    logic next_smm;
    logic trip;
    logic next_trip;
    logic trip_now;
    logic tristate;
    logic next_tristate;
    logic pbe;
    logic next_pbe;
    logic bus_en;
    logic next_bus_en;
    logic next_snoop_acc;
    logic next_int_acc;
    logic run_state;
    logic smi_edge;
    logic smi_accept;
    logic sg_enter;
    logic [SSC_EV_W-1:0] events;
    logic [SSC_CTRL_W-1:0] ctrl;

    // Next power state; thermal trip outranks init, init outranks requests.
    always_comb begin
        trip_now = junction_temp_in > SSC_TRIP_TEMP_C;
        next_trip = trip | trip_now;
        run_state = (state == SSC_NORMAL) || (state == SSC_STOP_GRANT);
        smi_edge = ~side_s.system_mgmt_int_n & smi_prev_n;
        smi_accept = smi_edge & run_state & ~system_mgmt_mode & init_q & ~trip;
        next_state = state;
        if (next_trip) begin
            next_state = SSC_HALTED;
        end else if (!init_q) begin
            next_state = SSC_NORMAL;
        end else begin
            unique case (state)
                SSC_NORMAL: begin
                    if (stp_act) begin
                        next_state = SSC_STOP_GRANT;
                    end
                end
                SSC_STOP_GRANT: begin
                    if (!stp_act) begin
                        next_state = SSC_NORMAL;
                    end else if (slp_act) begin
                        next_state = SSC_SLEEP;
                    end
                end
                SSC_SLEEP: begin
                    if (!slp_act) begin
                        next_state = SSC_STOP_GRANT;
                    end else if (dps_act || !bus_clock_present_in) begin
                        next_state = SSC_DEEP_SLEEP;
                    end
                end
                SSC_DEEP_SLEEP: begin
                    if (!dps_act && bus_clock_present_in) begin
                        next_state = SSC_SLEEP;
                    end
                end
                SSC_HALTED: begin
                    next_state = SSC_HALTED;
                end
                default: begin
                    next_state = SSC_NORMAL;
                end
            endcase
        end
        sg_enter = (state == SSC_NORMAL) && (next_state == SSC_STOP_GRANT);
        // Clock gates follow the state being entered.
        unique case (next_state)
            SSC_NORMAL: next_clk_en = SSC_CLK_ALL;
            SSC_STOP_GRANT: next_clk_en = SSC_CLK_SG;
            SSC_SLEEP: next_clk_en = SSC_CLK_PLL;
            SSC_HALTED: next_clk_en = SSC_CLK_PLL;
            default: next_clk_en = SSC_CLK_NONE;
        endcase
        // Management mode; the snapshot is taken at the moment of entry.
        next_saved_state = smi_accept ? state : saved_state;
        if (!init_q || trip) begin
            next_smm = 1'b0;
        end else if (smi_accept) begin
            next_smm = 1'b1;
        end else if (smm_exit_in) begin
            next_smm = 1'b0;
        end else begin
            next_smm = system_mgmt_mode;
        end
        // SMI seen low on the rising edge of init keeps the pins floating.
        next_tristate = init_q & (tristate | (~init_prev & ~side_s.system_mgmt_int_n));
        next_bus_en = init_q & ~next_tristate;
        // Break event: an interrupt or SMI while stop clock is held.
        next_pbe = stp_act & ctrl[SSC_CTRL_PBE_EN] & (pbe | int_req_in | smi_edge);
        // Sleep and deeper states drop snoops and interrupts on the floor.
        next_snoop_acc = snoop_req_in & run_state & ctrl[SSC_CTRL_SNOOP_EN];
        next_int_acc = int_req_in & run_state & ~trip;
        events = '0;
        events[SSC_EV_SG] = sg_enter;
        events[SSC_EV_SLEEP] = (state != SSC_SLEEP) && (next_state == SSC_SLEEP);
        events[SSC_EV_DEEP] = (state != SSC_DEEP_SLEEP) && (next_state == SSC_DEEP_SLEEP);
        events[SSC_EV_SMI] = smi_accept;
        events[SSC_EV_TRIP] = trip_now & ~trip;
        events[SSC_EV_PBE] = next_pbe & ~pbe;
    end

    // Registers of the power state group.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= SSC_NORMAL;
            saved_state <= SSC_NORMAL;
            clk_en_out <= SSC_CLK_ALL;
            init_q <= 1'b1;
            init_prev <= 1'b1;
            smi_prev_n <= 1'b1;
            system_mgmt_mode <= 1'b0;
            trip <= 1'b0;
            tristate <= 1'b0;
            pbe <= 1'b0;
            bus_en <= 1'b1;
            snoop_accept_out <= 1'b0;
            int_accept_out <= 1'b0;
        end else begin
            state <= next_state;
            saved_state <= next_saved_state;
            clk_en_out <= next_clk_en;
            init_q <= chip_init_n_in;
            init_prev <= init_q;
            smi_prev_n <= side_s.system_mgmt_int_n;
            system_mgmt_mode <= next_smm;
            trip <= next_trip;
            tristate <= next_tristate;
            pbe <= next_pbe;
            bus_en <= next_bus_en;
            snoop_accept_out <= next_snoop_acc;
            int_accept_out <= next_int_acc;
        end
    end

    // Acknowledge transactions for stop-grant entry and SMI acceptance.
    ssc_ack_issuer u_ack (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .sg_req_in(sg_enter),
        .smi_req_in(smi_accept),
        .valid_out(ack_valid_out),
        .ready_in(ack_ready_in),
        .type_out(ack_type_out)
    );

    // Status pins are open drain: the value is low, the enable asserts.
    assign exec_en_out = clk_en_out.core & ~trip;
    assign smm_active_out = system_mgmt_mode;
    assign bus_out_en_out = bus_en;
    assign thermal_trip_n_out = 1'b0;
    assign thermal_trip_n_oe_out = trip & ~tristate;
    assign pending_break_n_out = 1'b0;
    assign pending_break_n_oe_out = pbe & ~tristate;

    // =====================================================================
    // Avalon-MM register slave with one wait state
    logic done;
    logic next_done;
    logic wr_take;
    logic [SSC_DATA_W-1:0] next_rdata;
    logic [SSC_EV_W-1:0] status;
    logic [SSC_EV_W-1:0] next_status;
    logic [SSC_EV_W-1:0] mask;
    logic [SSC_EV_W-1:0] next_mask;
    logic [SSC_CTRL_W-1:0] next_ctrl;
    logic [SSC_INFO_W-1:0] info;

    // Read data is captured one edge early so it stands when waitrequest falls.
    always_comb begin
        avs_waitrequest_out = (avs_read_in | avs_write_in) & ~done;
        next_done = (avs_read_in | avs_write_in) & ~done;
        wr_take = avs_write_in & done;
        info = {pbe, bus_en, trip, tristate, system_mgmt_mode, saved_state, state};
        next_rdata = avs_readdata_out;
        if (avs_read_in && !done) begin
            unique case (avs_address_in)
                SSC_REG_STATUS: next_rdata = SSC_DATA_W'(status);
                SSC_REG_MASK: next_rdata = SSC_DATA_W'(mask);
                SSC_REG_STATE: next_rdata = SSC_DATA_W'(info);
                SSC_REG_CTRL: next_rdata = SSC_DATA_W'(ctrl);
                default: next_rdata = '0;
            endcase
        end
        // Write-one-to-clear, but an event in the same cycle survives.
        next_status = status;
        next_mask = mask;
        next_ctrl = ctrl;
        if (wr_take) begin
            unique case (avs_address_in)
                SSC_REG_STATUS: next_status = status & ~avs_writedata_in[SSC_EV_W-1:0];
                SSC_REG_MASK: next_mask = avs_writedata_in[SSC_EV_W-1:0];
                SSC_REG_CTRL: next_ctrl = avs_writedata_in[SSC_CTRL_W-1:0];
                default: next_status = status;
            endcase
        end
        next_status = next_status | events;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done <= 1'b0;
            avs_readdata_out <= '0;
            status <= '0;
            mask <= SSC_MASK_RST;
            ctrl <= SSC_CTRL_RST;
        end else begin
            done <= next_done;
            avs_readdata_out <= next_rdata;
            status <= next_status;
            mask <= next_mask;
            ctrl <= next_ctrl;
        end
    end

    assign irq_out = |(status & mask);

    // =====================================================================
    // Assertions
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic quiet;
    assign quiet = init_q & ~trip & ~trip_now;

    sequence s_sg_sleep_req;
        (state == SSC_STOP_GRANT) && stp_act && slp_act && quiet;
    endsequence

    sequence s_sleep_release;
        (state == SSC_SLEEP) && !slp_act && quiet;
    endsequence

    a_sleep_entry: assert property (s_sg_sleep_req |=> state == SSC_SLEEP)
        else $error("sleep not entered from stop-grant");
    a_sleep_clocks: assert property (state == SSC_SLEEP |-> clk_en_out == SSC_CLK_PLL)
        else $error("sleep left a unit clock running");
    a_sleep_deaf: assert property (state == SSC_SLEEP |=> !snoop_accept_out && !int_accept_out)
        else $error("sleep accepted a snoop or interrupt");
    a_sleep_exit: assert property (s_sleep_release |=> state == SSC_STOP_GRANT && clk_en_out == SSC_CLK_SG)
        else $error("sleep release did not return to stop-grant");
    a_deep_entry: assert property ((state == SSC_SLEEP) && slp_act && dps_act && quiet
        |=> state == SSC_DEEP_SLEEP)
        else $error("deep sleep not entered");
    a_sg_ack: assert property (sg_enter |=> ack_valid_out ##0 (state == SSC_STOP_GRANT || !quiet))
        else $error("stop-grant acknowledge missing");
    a_sg_clocks: assert property (state == SSC_STOP_GRANT |-> clk_en_out.bus && clk_en_out.lic
        && !clk_en_out.core)
        else $error("stop-grant clock gating wrong");
    a_sg_snoop: assert property (state == SSC_STOP_GRANT && snoop_req_in && ctrl[SSC_CTRL_SNOOP_EN]
        |=> snoop_accept_out)
        else $error("stop-grant dropped a snoop");
    a_resume_exec: assert property ((state == SSC_STOP_GRANT) && !stp_act && quiet
        |=> state == SSC_NORMAL && exec_en_out)
        else $error("execution not resumed");
    a_smi_entry: assert property (smi_accept |=> system_mgmt_mode && saved_state == $past(state)
        ##0 ack_valid_out)
        else $error("SMI entry incomplete");
    a_init_tristate: assert property ($rose(init_q) && !side_s.system_mgmt_int_n
        |=> !bus_out_en_out [*2])
        else $error("outputs not tristated at init release");
    a_thermal_halt: assert property (trip_now |=> !exec_en_out && thermal_trip_n_oe_out == !tristate)
        else $error("thermal trip did not halt");
    a_pbe_hold: assert property (pbe && stp_act && ctrl[SSC_CTRL_PBE_EN] |=> pbe)
        else $error("pending break dropped early");
    a_init_bus: assert property (!chip_init_n_in |-> ##[1:2] !bus_out_en_out)
        else $error("bus outputs not dropped within two clocks");
    a_sync_depth: assert property (side_s == $past(side_n_in, 2) || !$past(rst_n_in, 2))
        else $error("sideband synchroniser depth wrong");

endmodule

// ### hdl/ssc_pkg.sv
// Shared types and constants of the stop-grant and sleep state controller.
// Assumes one bus clock domain and an Avalon-MM register slave with 32-bit data.
package ssc_pkg;

    // =====================================================================
    // Power states and carriers
    localparam int SSC_STATE_W = 3;
    typedef enum logic [SSC_STATE_W-1:0] {
        SSC_NORMAL,
        SSC_STOP_GRANT,
        SSC_SLEEP,
        SSC_DEEP_SLEEP,
        SSC_HALTED
    } ssc_state_type;

    // Per-unit clock gates; the PLL bit keeps the loop itself running.
    typedef struct packed {
        logic pll;
        logic bus;
        logic lic;
        logic core;
    } ssc_clk_type;

    // Asynchronous sideband requests, all active low.
    typedef struct packed {
        logic stop_clock_request_n;
        logic sleep_request_n;
        logic deep_sleep_request_n;
        logic system_mgmt_int_n;
    } ssc_side_type;

    localparam int SSC_SIDE_W = $bits(ssc_side_type);
    localparam ssc_side_type SSC_SIDE_IDLE = 4'hf;
    localparam ssc_clk_type SSC_CLK_ALL = 4'hf;
    localparam ssc_clk_type SSC_CLK_SG = 4'he;
    localparam ssc_clk_type SSC_CLK_PLL = 4'h8;
    localparam ssc_clk_type SSC_CLK_NONE = 4'h0;

    // =====================================================================
    // Thermal trip
    localparam int SSC_TEMP_W = 8;
    localparam logic [SSC_TEMP_W-1:0] SSC_TRIP_TEMP_C = 8'h7d;

    // =====================================================================
    // Acknowledge transaction types
    localparam logic SSC_ACK_SG = 1'b0;
    localparam logic SSC_ACK_SMI = 1'b1;

    // =====================================================================
    // Register map, byte addresses
    localparam int SSC_ADDR_W = 4;
    localparam int SSC_DATA_W = 32;
    localparam logic [SSC_ADDR_W-1:0] SSC_REG_STATUS = 4'h0;
    localparam logic [SSC_ADDR_W-1:0] SSC_REG_MASK = 4'h4;
    localparam logic [SSC_ADDR_W-1:0] SSC_REG_STATE = 4'h8;
    localparam logic [SSC_ADDR_W-1:0] SSC_REG_CTRL = 4'hc;

    // Event bits of status and mask.
    localparam int SSC_EV_W = 6;
    localparam int SSC_EV_SG = 0;
    localparam int SSC_EV_SLEEP = 1;
    localparam int SSC_EV_DEEP = 2;
    localparam int SSC_EV_SMI = 3;
    localparam int SSC_EV_TRIP = 4;
    localparam int SSC_EV_PBE = 5;
    localparam logic [SSC_EV_W-1:0] SSC_MASK_RST = 6'h00;

    // Control bits.
    localparam int SSC_CTRL_W = 2;
    localparam int SSC_CTRL_PBE_EN = 0;
    localparam int SSC_CTRL_SNOOP_EN = 1;
    localparam logic [SSC_CTRL_W-1:0] SSC_CTRL_RST = 2'h3;

    // Width of the state readout word before zero fill.
    localparam int SSC_INFO_W = 2 * SSC_STATE_W + 5;

endpackage

// ### hdl/ssc_sync_bank.sv
// Two-stage synchronisers for a bank of asynchronous sideband inputs.
// Assumes the inputs idle at the reset value given by the parameter.
`timescale 1ns/100ps
module ssc_sync_bank #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Raw and synchronised levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // =====================================================================
    // One pair of flops per bit; the first flop feeds only the second.
    logic [WIDTH-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta[i] <= IDLE[i];
                    sync_out[i] <= IDLE[i];
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule

// ### hdl/ssc_ack_issuer.sv
// Queues acknowledge transactions and offers them with valid and ready.
// Assumes request pulses last one cycle; a pending type is never lost.
`timescale 1ns/100ps
module ssc_ack_issuer (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Request pulses
    input wire logic sg_req_in,
    input wire logic smi_req_in,
    // Transaction offer
    output logic valid_out,
    input wire logic ready_in,
    output logic type_out
);
    import ssc_pkg::*;

    // =====================================================================
    // Pending flags, indexed by transaction type.
    logic [1:0] pend;
    logic [1:0] next_pend;
    logic busy;
    logic next_busy;
    logic held;
    logic next_held;
    logic pick;

    // SMI goes first when idle; an offer stalled by ready stays unchanged.
    always_comb begin
        pick = pend[SSC_ACK_SMI] ? SSC_ACK_SMI : SSC_ACK_SG;
        valid_out = |pend;
        type_out = busy ? held : pick;
        next_busy = valid_out & ~ready_in;
        next_held = type_out;
        next_pend = pend;
        if (valid_out && ready_in) begin
            next_pend[type_out] = 1'b0;
        end
        // A new request wins over the clear of the same flag.
        next_pend[SSC_ACK_SG] = next_pend[SSC_ACK_SG] | sg_req_in;
        next_pend[SSC_ACK_SMI] = next_pend[SSC_ACK_SMI] | smi_req_in;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend <= 2'h0;
            busy <= 1'b0;
            held <= SSC_ACK_SG;
        end else begin
            pend <= next_pend;
            busy <= next_busy;
            held <= next_held;
        end
    end

endmodule

// ### verification/ssc_chipset_model.sv
// Chipset-side model: drives the sideband request levels and takes acknowledge transactions.
// Assumes the bench sets the wanted levels; acceptance of acknowledges is prompt or slow.
`timescale 1ns/100ps
module ssc_chipset_model (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Bench commands
    input wire ssc_pkg::ssc_side_type want_n_in,
    input wire logic slow_in,
    // Sideband and acknowledge
    output ssc_pkg::ssc_side_type side_n_out,
    input wire logic ack_valid_in,
    input wire logic ack_type_in,
    output logic ack_ready_out,
    output logic [7:0] sg_acks_out,
    output logic [7:0] smi_acks_out
);
    import ssc_pkg::*;
    logic [1:0] wait_cnt;
    // =====================================================================
    // A slow chipset holds off acceptance for three cycles to stress the offer hold.
    assign ack_ready_out = !slow_in || (wait_cnt == 2'h3);
    // Requests change after an edge; the device must not assume any phase. Counts tally acks by type.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            side_n_out <= SSC_SIDE_IDLE;
            wait_cnt <= 2'h0;
            sg_acks_out <= 8'h00;
            smi_acks_out <= 8'h00;
        end else begin
            side_n_out <= want_n_in;
            wait_cnt <= (ack_valid_in && !ack_ready_out) ? wait_cnt + 2'h1 : 2'h0;
            if (ack_valid_in && ack_ready_out && ack_type_in == SSC_ACK_SMI) begin
                smi_acks_out <= smi_acks_out + 8'h01;
            end
            if (ack_valid_in && ack_ready_out && ack_type_in == SSC_ACK_SG) begin
                sg_acks_out <= sg_acks_out + 8'h01;
            end
        end
    end
endmodule

// ### verification/test_ssc_top.sv
// Self-checking bench of the low-power state controller.
// Assumes the design package and the chipset model; registers are reached over Avalon-MM.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module test_ssc_top;
    import ssc_pkg::*;
    logic core_clk_in = 0, rst_n_in = 0, slow = 1, init_n = 1, clk_ok = 1, snoop = 0, intr = 0, rd_en = 0, wr_en = 0;
    logic ack_valid, ack_ready, ack_type, trip_oe, pbe_oe, system_mgmt_mode, bus_en, exec_en, snoop_acc, int_acc, irq, wreq, hit;
    logic [3:0] addr = 4'h0;
    logic [7:0] temp = 8'h19, sg_acks, smi_acks;
    logic [31:0] wdata = 32'h0, rdata, rd;
    ssc_side_type want = SSC_SIDE_IDLE, side;
    ssc_clk_type clk_en;
    int err_total = 0, checks = 0, cyc = 0;
    // =====================================================================
    // Clock, device and chipset model.
    always #25 core_clk_in = ~core_clk_in;
    ssc_top i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .side_n_in(side), .chip_init_n_in(init_n),
        .bus_clock_present_in(clk_ok), .junction_temp_in(temp), .snoop_req_in(snoop), .int_req_in(intr),
        .smm_exit_in(1'b0), .ack_valid_out(ack_valid), .ack_ready_in(ack_ready), .ack_type_out(ack_type),
        .clk_en_out(clk_en), .exec_en_out(exec_en), .snoop_accept_out(snoop_acc), .int_accept_out(int_acc),
        .smm_active_out(system_mgmt_mode), .bus_out_en_out(bus_en), .thermal_trip_n_out(), .thermal_trip_n_oe_out(trip_oe),
        .pending_break_n_out(), .pending_break_n_oe_out(pbe_oe), .avs_address_in(addr), .avs_read_in(rd_en),
        .avs_write_in(wr_en), .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .irq_out(irq));
    ssc_chipset_model i_chipset (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .want_n_in(want), .slow_in(slow),
        .side_n_out(side), .ack_valid_in(ack_valid), .ack_type_in(ack_type), .ack_ready_out(ack_ready),
        .sg_acks_out(sg_acks), .smi_acks_out(smi_acks));
    // =====================================================================
    // Every step ends on a rising edge; drives there are non-blocking, so reads see the settled values.
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    // One Avalon-MM access, held until the edge at which waitrequest is low; data is taken at that edge.
    // There is no local limit on the wait: only the bench timeout ends a hung access.
    task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
        addr <= a;
        wdata <= wd;
        wr_en <= wr;
        rd_en <= !wr;
        do begin
            @(posedge core_clk_in);
        end while (wreq !== 1'b0);
        r = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        // One idle edge keeps the next access from raising read or write in the same time step.
        wt(1);
    endtask
    task automatic snoop_try(output logic h);
        snoop <= 1'b1;
        wt(1);
        snoop <= 1'b0;
        h = snoop_acc;
        wt(1);
        h = h | snoop_acc;
    endtask
    task automatic state_is(input logic [2:0] e);
        logic [31:0] r;
        acc(1'b0, SSC_REG_STATE, 32'h0, r);
        `CHK("state", e, r[2:0])
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // A hang is cut short well beyond the hundred or so cycles the sequence needs.
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            print_verdict();
        end
    end
    // =====================================================================
    // Test sequence.
    initial begin
        wt(2);
        rst_n_in <= 1'b1;
        wt(1);
        acc(1'b0, SSC_REG_CTRL, 32'h0, rd); `CHK("ctrl", 32'h3, rd)
        acc(1'b0, 4'h2, 32'h0, rd); `CHK("unmapped", 32'h0, rd)
        $display("test registers done");
        want.stop_clock_request_n <= 1'b0;
        wt(5);
        `CHK("clk_en", SSC_CLK_SG, clk_en)
        `CHK("exec_en", 1'b0, exec_en)
        state_is(SSC_STOP_GRANT);
        snoop_try(hit); `CHK("snoop", 1'b1, hit)
        for (int i = 0; i < 20 && sg_acks != 8'h01; i++) wt(1);
        `CHK("sg_acks", 8'h01, sg_acks)
        acc(1'b1, SSC_REG_MASK, 32'h1, rd);
        `CHK("irq", 1'b1, irq)
        acc(1'b1, SSC_REG_STATUS, 32'h1, rd);
        `CHK("irq", 1'b0, irq)
        intr <= 1'b1;
        wt(1);
        intr <= 1'b0;
        wt(1);
        `CHK("int_acc", 1'b1, int_acc)
        wt(1);
        `CHK("pbe_oe", 1'b1, pbe_oe)
        $display("test stop grant done");
        want.sleep_request_n <= 1'b0;
        wt(5);
        `CHK("clk_en", SSC_CLK_PLL, clk_en)
        state_is(SSC_SLEEP);
        snoop_try(hit); `CHK("snoop", 1'b0, hit)
        clk_ok <= 1'b0;
        wt(4);
        state_is(SSC_DEEP_SLEEP);
        clk_ok <= 1'b1;
        wt(4);
        state_is(SSC_SLEEP);
        want.deep_sleep_request_n <= 1'b0;
        wt(4);
        state_is(SSC_DEEP_SLEEP);
        want.deep_sleep_request_n <= 1'b1;
        wt(4);
        state_is(SSC_SLEEP);
        want.sleep_request_n <= 1'b1;
        wt(5);
        `CHK("clk_en", SSC_CLK_SG, clk_en)
        `CHK("pbe_oe", 1'b1, pbe_oe)
        want.stop_clock_request_n <= 1'b1;
        wt(5);
        `CHK("clk_en", SSC_CLK_ALL, clk_en)
        `CHK("exec_en", 1'b1, exec_en)
        `CHK("pbe_oe", 1'b0, pbe_oe)
        $display("test sleep done");
        want.system_mgmt_int_n <= 1'b0;
        slow <= 1'b0;
        wt(5);
        `CHK("smm", 1'b1, system_mgmt_mode)
        for (int i = 0; i < 20 && smi_acks != 8'h01; i++) wt(1);
        `CHK("smi_acks", 8'h01, smi_acks)
        init_n <= 1'b0;
        wt(3);
        `CHK("bus_en", 1'b0, bus_en)
        init_n <= 1'b1;
        wt(4);
        `CHK("bus_en", 1'b0, bus_en)
        want.system_mgmt_int_n <= 1'b1;
        init_n <= 1'b0;
        wt(2);
        init_n <= 1'b1;
        wt(4);
        `CHK("bus_en", 1'b1, bus_en)
        $display("test smi and init done");
        temp <= 8'h7d;
        wt(3);
        `CHK("trip_oe", 1'b0, trip_oe)
        temp <= 8'h7e;
        wt(3);
        `CHK("trip_oe", 1'b1, trip_oe)
        `CHK("exec_en", 1'b0, exec_en)
        rst_n_in <= 1'b0;
        wt(2);
        rst_n_in <= 1'b1;
        temp <= 8'h19;
        wt(1);
        `CHK("trip_oe", 1'b0, trip_oe)
        $display("test thermal done");
        print_verdict();
    end
endmodule
